// >>> smic_ctrl.sv
// Slave-mode interrupt controller for three timers and two DMA channels.
// Assumes src_req, core_ack and slave_mode_sel come from core_clk logic;
// select pin is asynchronous and is synchronised here.
`timescale 1ns/1ps
module smic_ctrl
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [5:0] src_req,
  input wire logic slave_mode_sel,
  input wire logic cpu_interrupt_input,
  input wire logic slave_select_input,
  input wire logic core_ack,
  output logic cpu_int_req,
  output logic slave_request_output,
  output logic acknowledge_output,
  output logic [7:0] vector_out,
  output logic vector_valid
);

  // ****************************************
  // State
  // ****************************************
  logic [5:0] in_service_bit;
  logic [5:0] request;
  logic [5:0] mask;
  logic [2:0] source_priority_field [6];
  logic [2:0] level_threshold;
  logic [4:0] vec_base;
  logic [5:0] src_req_q;
  logic [1:0] sel_sync;
  logic [1:0] cpu_sync;
  logic ack_q;

  // ****************************************
  // Decode helpers
  // ****************************************
  // Maps a control-word offset to its source, or NSRC when none
  function automatic int smic_ctl_index(input logic [7:0] a);
    int r;
    r = smic_pkg::NSRC;
    unique case (a)
      smic_pkg::OFS_CTL_T0: r = smic_pkg::SRC_T0;
      smic_pkg::OFS_CTL_DMA0: r = smic_pkg::SRC_DMA0;
      smic_pkg::OFS_CTL_DMA1: r = smic_pkg::SRC_DMA1;
      smic_pkg::OFS_CTL_T1: r = smic_pkg::SRC_T1;
      smic_pkg::OFS_CTL_T2: r = smic_pkg::SRC_T2;
      default: r = smic_pkg::NSRC;
    endcase
    return r;
  endfunction : smic_ctl_index

  logic wr_end_cmd;
  logic wr_mask;
  logic wr_thresh;
  logic wr_inserv;
  logic wr_request;
  logic wr_vector;
  int wr_ctl_idx;
  int rd_ctl_idx;

  assign wr_end_cmd = reg_wr && (reg_addr == smic_pkg::OFS_END_CMD); // RULE_02
  assign wr_mask = reg_wr && (reg_addr == smic_pkg::OFS_MASK);
  assign wr_thresh = reg_wr && (reg_addr == smic_pkg::OFS_THRESH);
  assign wr_inserv = reg_wr && (reg_addr == smic_pkg::OFS_INSERV);
  assign wr_request = reg_wr && (reg_addr == smic_pkg::OFS_REQUEST);
  assign wr_vector = reg_wr && (reg_addr == smic_pkg::OFS_VECTOR); // RULE_21
  assign wr_ctl_idx = reg_wr ? smic_ctl_index(reg_addr) : smic_pkg::NSRC;
  assign rd_ctl_idx = smic_ctl_index(reg_addr);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      sel_sync <= 2'h0;
      cpu_sync <= 2'h0;
    end
    else
    begin
      sel_sync <= {sel_sync[0], slave_select_input};
      cpu_sync <= {cpu_sync[0], cpu_interrupt_input};
    end
  end

  // CPU interrupt pin feeds the core through the two-stage synchroniser in every mode
  assign cpu_int_req = cpu_sync[1]; // RULE_19

  // ****************************************
  // Priority resolution
  // ****************************************
  logic [2:0] svc_level;
  logic svc_any;
  logic [5:0] eligible;
  logic win_valid;
  logic [2:0] win_level;
  logic [5:0] win_onehot;

  // Highest in-service level gates nesting
  always_comb
  begin
    svc_level = 3'h7;
    svc_any = 1'b0;
    for (int i = 0; i < smic_pkg::NSRC; i++)
    begin
      if (in_service_bit[i] && (!svc_any || source_priority_field[i] < svc_level))
      begin
        svc_level = source_priority_field[i];
        svc_any = 1'b1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < smic_pkg::NSRC; g++)
    begin : g_elig
      assign eligible[g] = smic_pkg::SRC_PRESENT[g] && request[g]
        && !mask[g] // RULE_08
        && (source_priority_field[g] <= level_threshold) // RULE_12
        && (!svc_any || source_priority_field[g] <= svc_level); // RULE_20
    end
  endgenerate

  // Lowest code wins; equal codes resolve to the lower source index
  always_comb
  begin
    win_valid = 1'b0;
    win_level = 3'h7;
    win_onehot = 6'h00;
    for (int i = 0; i < smic_pkg::NSRC; i++)
    begin
      if (eligible[i] && (!win_valid || source_priority_field[i] < win_level)) // RULE_22
      begin
        win_valid = 1'b1;
        win_level = source_priority_field[i];
        win_onehot = 6'h00;
        win_onehot[i] = 1'b1;
      end
    end
  end

  // Acknowledge is ours only when the master has selected this slave
  logic take_ack;
  assign take_ack = core_ack && sel_sync[1] && slave_mode_sel && win_valid;

  // ****************************************
  // Request flags
  // ****************************************
  logic [5:0] req_rise;
  assign req_rise = src_req & ~src_req_q & smic_pkg::SRC_PRESENT;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      src_req_q <= 6'h00;
    end
    else
    begin
      src_req_q <= src_req;
    end
  end

  // Edge-sensed; a new edge wins over a same-cycle acknowledge or write
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      request <= 6'h00; // RULE_16
    end
    else
    begin
      request <= ((wr_request
        ? ((request & ~smic_pkg::REQ_SW_BITS) | (reg_wdata[5:0] & smic_pkg::REQ_SW_BITS)) // RULE_07
        : request)
        & ~(take_ack ? win_onehot : 6'h00)) // RULE_06
        | req_rise; // RULE_06
    end
  end

  // ****************************************
  // In-service flags
  // ****************************************
  logic [5:0] end_clear;
  always_comb
  begin
    end_clear = 6'h00;
    for (int i = 0; i < smic_pkg::NSRC; i++)
    begin
      end_clear[i] = wr_end_cmd && (source_priority_field[i] == reg_wdata[2:0]); // RULE_03
    end
  end

  // Acknowledge set wins over a same-cycle end command
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      in_service_bit <= 6'h00; // RULE_16
    end
    else
    begin
      in_service_bit <= ((wr_inserv ? (reg_wdata[5:0] & smic_pkg::SRC_PRESENT) : in_service_bit) // RULE_04
        & ~end_clear)
        | (take_ack ? win_onehot : 6'h00); // RULE_05
    end
  end

  // ****************************************
  // Mask and control words
  // ****************************************
  // One mask store, written through either view
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      mask <= smic_pkg::MASK_RESET; // RULE_16
    end
    else if (wr_mask)
    begin
      mask <= reg_wdata[5:0]; // RULE_09
    end
    else if (wr_ctl_idx != smic_pkg::NSRC)
    begin
      mask[wr_ctl_idx] <= reg_wdata[smic_pkg::MSK_BIT]; // RULE_09
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < smic_pkg::NSRC; i++)
      begin
        source_priority_field[i] <= smic_pkg::PR_RESET; // RULE_15
      end
    end
    else if (wr_ctl_idx != smic_pkg::NSRC)
    begin
      source_priority_field[wr_ctl_idx] <= reg_wdata[smic_pkg::PR_LSB +: smic_pkg::PR_W]; // RULE_10
    end
  end

  // ****************************************
  // Threshold and vector base
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      level_threshold <= smic_pkg::THRESH_RESET; // RULE_17
    end
    else if (wr_thresh)
    begin
      level_threshold <= reg_wdata[2:0]; // RULE_12
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      vec_base <= smic_pkg::VEC_RESET;
    end
    else if (wr_vector)
    begin
      vec_base <= reg_wdata[smic_pkg::VEC_LSB +: smic_pkg::VEC_W];
    end
  end

  // ****************************************
  // Master interface
  // ****************************************
  // Request is withheld until software leaves master mode
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      slave_request_output <= 1'b0; // RULE_17
      acknowledge_output <= 1'b0;
      ack_q <= 1'b0;
    end
    else
    begin
      slave_request_output <= slave_mode_sel && win_valid; // RULE_18
      acknowledge_output <= slave_mode_sel && core_ack; // RULE_19
      ack_q <= take_ack;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      vector_out <= 8'h00;
    end
    else if (take_ack)
    begin
      vector_out <= {vec_base, win_level}; // RULE_11
    end
  end

  assign vector_valid = ack_q;

  // ****************************************
  // Register read
  // ****************************************
  logic [15:0] rd_mux;
  always_comb
  begin
    rd_mux = 16'h0000;
    unique case (reg_addr)
      smic_pkg::OFS_VECTOR: rd_mux[smic_pkg::VEC_LSB +: smic_pkg::VEC_W] = vec_base;
      smic_pkg::OFS_MASK: rd_mux[5:0] = mask;
      smic_pkg::OFS_THRESH: rd_mux[2:0] = level_threshold;
      smic_pkg::OFS_INSERV: rd_mux[5:0] = in_service_bit;
      smic_pkg::OFS_REQUEST: rd_mux[5:0] = request;
      // Individual timer requests; halt flag bit stays zero
      smic_pkg::OFS_STATUS: rd_mux[2:0] = {request[smic_pkg::SRC_T2],
        request[smic_pkg::SRC_T1], request[smic_pkg::SRC_T0]}; // RULE_13
      default:
      begin
        // Nested, level-trigger and cascade bits do not exist and read zero
        if (rd_ctl_idx != smic_pkg::NSRC)
        begin
          rd_mux[smic_pkg::PR_LSB +: smic_pkg::PR_W] = source_priority_field[rd_ctl_idx]; // RULE_14
          rd_mux[smic_pkg::MSK_BIT] = mask[rd_ctl_idx]; // RULE_09
        end
      end
    endcase
  end

  // End-of-service register is write-only and reads zero
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rd_mux; // RULE_01
    end
  end

endmodule : smic_ctrl

// >>> smic_pkg.sv
// Constants of the slave-mode interrupt controller: offsets, fields, resets.
// Assumes a single core_clk domain and a 16-bit peripheral register port.
// Operation
// RULE_01: Registers sit in the internal peripheral control block address space.
// RULE_02: End-of-service register is write-only; each write issues an end command.
// RULE_03: End command clears in-service bits whose priority equals written level code.
// RULE_04: In-service register is read/write; bits 2,3 DMA, bits 0,4,5 timers.
// RULE_05: Acknowledging a source's request sets its in-service bit.
// RULE_06: Request bit sets on source request, clears on acknowledge.
// RULE_07: Request bits 0 and 1 are read/write; the rest read-only.
// RULE_08: A set mask bit suppresses every interrupt from its source.
// RULE_09: Mask bits are one storage seen through mask register and control words.
// RULE_10: Each timer and DMA channel has a control word: 3-bit priority, mask.
// RULE_11: Vector is five programmed upper bits plus serviced priority level.
// RULE_12: Threshold register holds three bits; lower priorities are masked.
// RULE_13: Status register is as in master mode but without DMA halt flag.
// RULE_14: Reset clears special nested, level-trigger and cascade bits.
// RULE_15: Reset sets all priority fields to lowest level.
// RULE_16: Reset clears in-service and request bits and sets all masks.
// RULE_17: Reset sets threshold to no masking and starts in master mode.
// RULE_18: Software selects slave operation through relocation bit 14.
// RULE_19: Pins become CPU interrupt in, slave request out, select in, acknowledge out.
// RULE_20: After acknowledge only equal or higher priority levels pass until end.
// RULE_21: Vector register at offset 20H, end-of-service register at 22H.
// RULE_22: Among eligible sources the lowest priority code is signalled.
package smic_pkg;
  localparam int NSRC = 6;
  localparam int AW = 8;
  localparam int DW = 16;
  // Register offsets within the peripheral control block
  localparam logic [7:0] OFS_VECTOR = 8'h20;
  localparam logic [7:0] OFS_END_CMD = 8'h22;
  localparam logic [7:0] OFS_MASK = 8'h28;
  localparam logic [7:0] OFS_THRESH = 8'h2a;
  localparam logic [7:0] OFS_INSERV = 8'h2c;
  localparam logic [7:0] OFS_REQUEST = 8'h2e;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_CTL_T0 = 8'h32;
  localparam logic [7:0] OFS_CTL_DMA0 = 8'h34;
  localparam logic [7:0] OFS_CTL_DMA1 = 8'h36;
  localparam logic [7:0] OFS_CTL_T1 = 8'h38;
  localparam logic [7:0] OFS_CTL_T2 = 8'h3a;
  // Source bit positions
  localparam int SRC_T0 = 0;
  localparam int SRC_DMA0 = 2;
  localparam int SRC_DMA1 = 3;
  localparam int SRC_T1 = 4;
  localparam int SRC_T2 = 5;
  localparam logic [5:0] SRC_PRESENT = 6'h3d;
  localparam logic [5:0] REQ_SW_BITS = 6'h03;
  // Field layout
  localparam int PR_LSB = 0;
  localparam int PR_W = 3;
  localparam int MSK_BIT = 3;
  localparam int VEC_LSB = 3;
  localparam int VEC_W = 5;
  // Reset values
  localparam logic [2:0] PR_RESET = 3'h7;
  localparam logic [2:0] THRESH_RESET = 3'h7;
  localparam logic [5:0] MASK_RESET = 6'h3f;
  localparam logic [4:0] VEC_RESET = 5'h00;
endpackage : smic_pkg

// >>> smic_monitor.sv
// Concurrent checks on the ports of the slave-mode interrupt controller.
// Assumes one core_clk domain with synchronous active-low resetn.
`timescale 1ns/1ps
module smic_monitor
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic slave_mode_sel,
  input wire logic cpu_interrupt_input,
  input wire logic core_ack,
  input wire logic cpu_int_req,
  input wire logic slave_request_output,
  input wire logic acknowledge_output,
  input wire logic vector_valid
);
  // ****************
  // Assertions
  // ****************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  ack_echo_a: assert property (core_ack && slave_mode_sel |=> acknowledge_output)
    else $error("acknowledge output missed");
  ack_quiet_a: assert property (!core_ack |=> !acknowledge_output)
    else $error("acknowledge output without ack");
  int_pass_a: assert property ($past(resetn) && $past(resetn, 2) |-> cpu_int_req == $past(cpu_interrupt_input, 2))
    else $error("cpu interrupt not passed through");
  master_quiet_a: assert property (!slave_mode_sel |=> !slave_request_output)
    else $error("slave request in master mode");
  vec_cause_a: assert property (vector_valid |-> $past(core_ack) && $past(slave_mode_sel))
    else $error("vector without acknowledge");
  end_read_a: assert property (reg_rd && reg_addr == smic_pkg::OFS_END_CMD |=> reg_rdata == 16'h0000)
    else $error("end command register readable");
  status_top_a: assert property (reg_rd && reg_addr == smic_pkg::OFS_STATUS |=> reg_rdata[15:3] == 13'h0000)
    else $error("status upper bits set");
  unmapped_a: assert property (reg_rd && reg_addr == 8'h24 |=> reg_rdata == 16'h0000)
    else $error("unmapped offset returned data");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  cover property (vector_valid);
  cover property (core_ack && slave_mode_sel);
  cover property (reg_rd && reg_addr == smic_pkg::OFS_END_CMD);
endmodule : smic_monitor

bind smic_ctrl smic_monitor u_mon (.core_clk, .resetn, .reg_addr, .reg_rd, .reg_rdata, .slave_mode_sel,
  .cpu_interrupt_input, .core_ack, .cpu_int_req, .slave_request_output, .acknowledge_output, .vector_valid);

// >>> smic_master_model.sv
// Behavioural external master controller plus core acknowledge path.
// Assumes the slave's outputs change on core_clk rising edges.
`timescale 1ns/1ps
module smic_master_model
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic slave_request_output,
  input wire logic vector_valid,
  input wire logic [7:0] vector_out,
  input wire logic [3:0] delay,
  output logic slave_select_input,
  output logic core_ack,
  output logic [7:0] last_vec,
  output int ack_count
);
  int wait_cnt;
  initial
  begin
    slave_select_input = 1'b0;
    core_ack = 1'b0;
    ack_count = 0;
  end
  // ****************
  // Select and acknowledge
  // ****************
  // Select is held past the two-stage synchroniser before the ack pulse
  always @(posedge core_clk)
  begin
    #1;
    if (!resetn)
    begin
      slave_select_input = 1'b0;
      core_ack = 1'b0;
    end
    else if (slave_request_output && !slave_select_input)
    begin
      slave_select_input = 1'b1;
      wait_cnt = delay + 3;
    end
    else if (slave_select_input && wait_cnt > 0)
    begin
      wait_cnt--;
      core_ack = (wait_cnt == 0);
    end
    else
    begin
      slave_select_input = 1'b0;
      core_ack = 1'b0;
    end
    if (vector_valid)
    begin
      last_vec = vector_out;
      ack_count++;
    end
  end
endmodule : smic_master_model

// >>> smic_ctrl_tb.sv
// Self-checking testbench for the slave-mode interrupt controller.
// Assumes the master model answers requests; register access via strobes.
`timescale 1ns/1ps
module smic_ctrl_tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [5:0] src_req = 6'h00;
  logic slave_mode_sel = 1'b0;
  logic cpu_pin = 1'b0;
  logic sel_pin;
  logic ack;
  logic sro;
  logic vvalid;
  logic [7:0] vec;
  logic [7:0] last_vec;
  logic [3:0] delay = 4'h0;
  int ack_count;
  int err_count = 0;
  int check_count = 0;
  logic [7:0] ofs [13] = '{8'h28, 8'h2a, 8'h2c, 8'h2e, 8'h30, 8'h20, 8'h22, 8'h24, 8'h32, 8'h34, 8'h36,
    8'h38, 8'h3a};
  logic [15:0] ev [13] = '{16'h003f, 16'h0007, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h000f, 16'h000f, 16'h000f, 16'h000f, 16'h000f};
  always #12.5 core_clk = ~core_clk;
  smic_ctrl uut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .src_req(src_req),
    .slave_mode_sel(slave_mode_sel), .cpu_interrupt_input(cpu_pin), .slave_select_input(sel_pin),
    .core_ack(ack), .cpu_int_req(), .slave_request_output(sro), .acknowledge_output(),
    .vector_out(vec), .vector_valid(vvalid));
  smic_master_model u_master (.core_clk(core_clk), .resetn(resetn), .slave_request_output(sro),
    .vector_valid(vvalid), .vector_out(vec), .delay(delay), .slave_select_input(sel_pin),
    .core_ack(ack), .last_vec(last_vec), .ack_count(ack_count));
  // ****************
  // Tasks
  // ****************
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    @(posedge core_clk);
    #1;
    chk($sformatf("reg %h", a), exp, reg_rdata);
  endtask : rd
  // Bounded wait for the master model to collect a vector
  task wait_ack(input int n);
    for (int i = 0; i < 80 && ack_count < n; i++)
      @(posedge core_clk);
    #1;
    chk("ack count", 16'(n), 16'(ack_count));
  endtask : wait_ack
  task close_out;
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  // ****************
  // Sequence
  // ****************
  initial
  begin
    repeat (3) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    for (int i = 0; i < 13; i++)
      rd(ofs[i], ev[i]);
    wr(8'h2e, 16'hffff);
    rd(8'h2e, 16'h0003);
    wr(8'h2e, 16'h0000);
    wr(8'h32, 16'h0003);
    wr(8'h34, 16'h0001);
    wr(8'h3a, 16'h0005);
    wr(8'h20, 16'h00a8);
    rd(8'h28, 16'h001a);
    wr(8'h28, 16'h001e);
    rd(8'h34, 16'h0009);
    wr(8'h28, 16'h001a);
    rd(8'h20, 16'h00a8);
    src_req[0] = 1'b1;
    cpu_pin = 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    chk("slave request", 16'h0000, {15'h0000, sro});
    rd(8'h2e, 16'h0001);
    slave_mode_sel = 1'b1;
    wait_ack(1);
    chk("vector", 16'h00ab, {8'h00, last_vec});
    rd(8'h2c, 16'h0001);
    rd(8'h2e, 16'h0000);
    src_req[5:4] = 2'b11;
    repeat (8) @(posedge core_clk);
    #1;
    chk("slave request", 16'h0000, {15'h0000, sro});
    rd(8'h30, 16'h0006);
    src_req[2] = 1'b1;
    wait_ack(2);
    chk("vector", 16'h00a9, {8'h00, last_vec});
    rd(8'h2c, 16'h0005);
    wr(8'h22, 16'h0001);
    rd(8'h2c, 16'h0001);
    wr(8'h2a, 16'h0004);
    wr(8'h22, 16'h0003);
    rd(8'h2c, 16'h0000);
    repeat (8) @(posedge core_clk);
    #1;
    chk("slave request", 16'h0000, {15'h0000, sro});
    delay = 4'h6;
    wr(8'h2a, 16'h0007);
    wait_ack(3);
    chk("vector", 16'h00ad, {8'h00, last_vec});
    // Clear the level 5 service so only the mask keeps the pending timer out
    wr(8'h22, 16'h0005);
    repeat (20) @(posedge core_clk);
    #1;
    chk("ack count", 16'h0003, 16'(ack_count));
    // Unmask timer 1 through its control word, then raise a better-placed request
    wr(8'h38, 16'h0006);
    wr(8'h2e, 16'h0001);
    wait_ack(4);
    chk("vector", 16'h00ab, {8'h00, last_vec});
    rd(8'h28, 16'h000a);
    wr(8'h2c, 16'h0011);
    rd(8'h2c, 16'h0011);
    close_out;
  end
  // Whole sequence takes well under 600 cycles
  initial
  begin
    repeat (3000) @(posedge core_clk);
    err_count++;
    close_out;
  end
endmodule : smic_ctrl_tb
